/* File: verilog/tdc_cfg.svh */
// Address, field and timing constants of the configuration bank
`ifndef TDC_CFG_SVH
`define TDC_CFG_SVH
`define TDC_ADR_W3 4'h3
`define TDC_ADR_W4 4'h4
`define TDC_ADR_W5 4'h5
`define TDC_ADR_W6 4'h6
`define TDC_ADR_W7 4'h7
`define TDC_ADR_W14 4'he
`define TDC_IDX_W3 3'h0
`define TDC_IDX_W4 3'h1
`define TDC_IDX_W5 3'h2
`define TDC_IDX_W6 3'h3
`define TDC_IDX_W7 3'h4
`define TDC_IDX_W14 3'h5
`define TDC_IDX_NONE 3'h7
`define TDC_RESET_WORD 28'h0000000
`define TDC_W4_PULSE_MASK 28'h1c00000
`define TDC_FILL_INV 28'h00000ff
`define TDC_B_FULL_RST 22
`define TDC_B_RED_RST 23
`define TDC_B_SOFT_TRIG 24
`define TDC_B_RST_TRIG_FULL 23
`define TDC_B_RST_TRIG_RED 24
`define TDC_B_RST_GATE_FULL 25
`define TDC_B_RST_GATE_RED 26
`define TDC_TREF_NS 25
`define TDC_CLK_NS 100
`define TDC_REF_PER_CLK (`TDC_CLK_NS / `TDC_TREF_NS)
`endif

/* File: verilog/tdc_pkg.sv */
// Types shared by the configuration bank
package tdc_pkg;
  typedef logic [27:0] tdc_word_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_READ = 2'h1,
    BUS_WRITE = 2'h3
  } tdc_bus_e;

  typedef struct packed {
    logic [4:0] fine_resolution_factor;
    logic single_ended_to_diff_test;
    logic [7:0] internal_launch_period;
    logic quiet_mode;
    logic m_mode;
    logic [11:0] pulse_pair_adjust;
    logic empty_pin_always_driven;
    logic window_timer_on_launch;
    logic window_timer_on_hit;
    logic [17:0] launch_offset_a;
    logic [17:0] launch_offset_b;
    logic hit_block_until_launch;
    logic launch_block_after_launch;
    logic [7:0] fill_level;
    logic diff_input_fanout_select;
    logic diff_receiver_power;
    logic [7:0] pll_fast_divider;
    logic [2:0] pll_reference_divider;
    logic resolution_adjust_enable;
    logic pll_phase_invert;
    logic pll_loop_open;
    logic [12:0] window_timer_count;
    logic half_width_bus_select;
  } tdc_cfg_s;

  typedef struct packed {
    logic csn;
    logic rdn;
    logic wrn;
    logic [3:0] adr;
    tdc_word_t data;
    logic trig;
    logic gate_n;
  } tdc_pins_s;

  typedef struct packed {
    tdc_pins_s s1;
    tdc_pins_s s2;
    tdc_bus_e bus;
    tdc_word_t [5:0] regs;
    tdc_word_t rd_data;
    tdc_word_t wr_data;
    logic wr_half;
    logic rd_half;
    logic [15:0] wr_lo;
    logic trig_prev;
    logic armed;
    logic launched;
    logic [9:0] launch_acc;
    logic launch_pulse;
    logic timer_run;
    logic [13:0] timer_acc;
    logic timer_done;
    logic full_rst;
    logic red_rst;
  } tdc_state_s;
endpackage : tdc_pkg

/* File: verilog/tdc_cfg_bank.sv */
// Configuration bank, words 3 to 7 and 14, on the asynchronous parallel bus
//
// How it works
// RULE1: M-mode resolution factor from word3 bits 0-4
// RULE2: word3 bit27 routes single-ended inputs to differential
// RULE3: I-mode internal launch every N+1 reference periods
// RULE4: quiet mode holds post-processing until trigger
// RULE5: word4 bit9 selects M-mode; host enables quiet
// RULE6: host writes pulse-pair adjust fields as zero
// RULE7: word4 bit22 full reset, configuration kept
// RULE8: word4 bit23 reduced reset, FIFOs also kept
// RULE9: word4 bit25 keeps empty pin driven
// RULE10: launch or hit pulse starts window timer
// RULE11: launch offsets from word5, plus word6 in G-mode
// RULE12: block hits before launch, launches after launch
// RULE13: trigger pin high resets when quiet off
// RULE14: gate pin low resets when pin unused
// RULE15: load level flags when occupancy reaches fill level
// RULE16: fill level reads back inverted
// RULE17: I-mode differential stops fan to odd/even channels
// RULE18: word6 bit27 powers differential receivers
// RULE19: PLL dividers from word7
// RULE20: word7 resolution adjust, phase invert, loop open
// RULE21: window timer runs word7 bits 15-27 periods
// RULE22: word14 bit4 selects paired 16-bit transfers
// RULE23: every configuration word reads back
// RULE24: counts measured in 25 ns reference periods
// RULE25: reset and trigger bits clear themselves
`include "tdc_cfg.svh"

module tdc_cfg_bank (
  input wire logic mclk_in, // 10 MHz clock
  input wire logic reset_in, // Asynchronous reset, high
  input wire logic bus_cs_n_in, // Chip select pin, low
  input wire logic bus_rd_n_in, // Read strobe pin, low
  input wire logic bus_wr_n_in, // Write strobe pin, low
  input wire logic [3:0] bus_adr_in, // Word address pins
  input wire logic [27:0] bus_data_in, // Data pins, input side
  output logic [27:0] bus_data_out, // Data pins, driven side
  output logic bus_data_oe_n_out, // Data pin enable, low drives
  input wire logic trigger_pin_in, // Post-processing trigger pin
  input wire logic output_gate_pin_in, // Gate pin, low active
  input wire logic gate_pin_unused_in, // Gate pin free for resets
  input wire logic i_mode_in, // I-mode selected
  input wire logic g_mode_in, // G-mode selected
  input wire logic launch_in, // Launch pulse from input logic
  input wire logic hit_in, // Hit pulse from input logic
  input wire logic [7:0] fifo1_level_in, // Interface FIFO1 occupancy
  input wire logic [7:0] fifo2_level_in, // Interface FIFO2 occupancy
  input wire logic empty_in, // Interface FIFO empty state
  input wire logic single_ended_launch_input, // Single-ended launch
  input wire logic [7:0] se_stop_in, // Single-ended stops 1 to 8
  input wire logic diff_launch_input, // Differential launch
  input wire logic [1:0] diff_stop_in, // Differential stops 1, 2
  output logic [2:0] diff_path_out, // Launch, stop1, stop2 paths
  output logic [7:0] stop_ch_out, // Stop channel sources
  output tdc_pkg::tdc_cfg_s cfg_out, // Decoded configuration
  output logic [17:0] launch_offset_out, // Applied launch offset
  output logic postproc_enable_out, // Post-processing may run
  output logic internal_launch_out, // Internal launch pulse
  output logic window_timer_end_out, // Window timer expiry pulse
  output logic hit_enable_out, // Hit inputs accepted
  output logic launch_enable_out, // Launch inputs accepted
  output logic full_reset_out, // Full reset pulse
  output logic reduced_reset_out, // Reduced reset pulse
  output logic [1:0] load_level_flags, // Fill-level flags
  output logic empty_flag_pin, // Empty pin level
  output logic empty_pin_oe_n_out // Empty pin enable, low drives
);

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic [2:0] word_index(input logic [3:0] adr);
    case (adr)
      `TDC_ADR_W3: word_index = `TDC_IDX_W3;
      `TDC_ADR_W4: word_index = `TDC_IDX_W4;
      `TDC_ADR_W5: word_index = `TDC_IDX_W5;
      `TDC_ADR_W6: word_index = `TDC_IDX_W6;
      `TDC_ADR_W7: word_index = `TDC_IDX_W7;
      `TDC_ADR_W14: word_index = `TDC_IDX_W14;
      default: word_index = `TDC_IDX_NONE;
    endcase
  endfunction

  tdc_pkg::tdc_state_s st_q;
  tdc_pkg::tdc_state_s st_d;
  tdc_pkg::tdc_pins_s pins;
  tdc_pkg::tdc_cfg_s cfg;
  tdc_pkg::tdc_word_t w3, w4, w5, w6, w7, w14;
  tdc_pkg::tdc_word_t commit_word;
  tdc_pkg::tdc_word_t rd_word;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic commit;
  logic soft_full, soft_red, soft_trig;
  logic pin_full, pin_red;
  logic trig_rise;
  logic any_rst;
  logic timer_go;
  logic [9:0] launch_next;
  logic [9:0] launch_span;
  logic [13:0] timer_next;

  assign pins = '{csn: bus_cs_n_in, rdn: bus_rd_n_in, wrn: bus_wr_n_in,
                  adr: bus_adr_in, data: bus_data_in,
                  trig: trigger_pin_in, gate_n: output_gate_pin_in};

  // ==========================================================
  // Field decode
  // ==========================================================
  assign w3 = st_q.regs[`TDC_IDX_W3];
  assign w4 = st_q.regs[`TDC_IDX_W4];
  assign w5 = st_q.regs[`TDC_IDX_W5];
  assign w6 = st_q.regs[`TDC_IDX_W6];
  assign w7 = st_q.regs[`TDC_IDX_W7];
  assign w14 = st_q.regs[`TDC_IDX_W14];

  always_comb begin
    cfg.fine_resolution_factor = w3[4:0]; // [RULE1]
    cfg.single_ended_to_diff_test = w3[27];
    cfg.internal_launch_period = w4[7:0];
    cfg.quiet_mode = w4[8];
    cfg.m_mode = w4[9]; // [RULE5]
    cfg.pulse_pair_adjust = w4[21:10];
    cfg.empty_pin_always_driven = w4[25];
    cfg.window_timer_on_launch = w4[26];
    cfg.window_timer_on_hit = w4[27];
    cfg.launch_offset_a = w5[17:0];
    cfg.launch_offset_b = w6[25:8];
    cfg.hit_block_until_launch = w5[21];
    cfg.launch_block_after_launch = w5[22];
    cfg.fill_level = w6[7:0];
    cfg.diff_input_fanout_select = w6[26];
    cfg.diff_receiver_power = w6[27]; // [RULE18]
    cfg.pll_fast_divider = w7[7:0]; // [RULE19]
    cfg.pll_reference_divider = w7[10:8]; // [RULE19]
    cfg.resolution_adjust_enable = w7[11]; // [RULE20]
    cfg.pll_phase_invert = w7[12]; // [RULE20]
    cfg.pll_loop_open = w7[13]; // [RULE20]
    cfg.window_timer_count = w7[27:15];
    cfg.half_width_bus_select = w14[4];
  end

  assign cfg_out = cfg;

  // G-mode adds the second offset field on top of the first
  assign launch_offset_out = g_mode_in ?
    cfg.launch_offset_a + cfg.launch_offset_b :
    cfg.launch_offset_a; // [RULE11]

  // ==========================================================
  // Input routing
  // ==========================================================
  assign diff_path_out = cfg.single_ended_to_diff_test ?
    {se_stop_in[1], se_stop_in[0], single_ended_launch_input} :
    {diff_stop_in, diff_launch_input}; // [RULE2]

  // Channel 1 is index 0, so even indices are the odd channels;
  // the per-channel disable lives in the core and still applies
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_fan
      assign stop_ch_out[ch] =
        (i_mode_in && cfg.diff_input_fanout_select) ?
        diff_stop_in[ch % 2] : se_stop_in[ch]; // [RULE17]
    end
  endgenerate

  // ==========================================================
  // Bus write path
  // ==========================================================
  assign wr_idx = word_index(st_q.s2.adr);
  assign rd_idx = word_index(st_q.s2.adr);
  assign commit = (st_q.bus == tdc_pkg::BUS_WRITE) && st_q.s2.wrn &&
                  (!cfg.half_width_bus_select || st_q.wr_half);

  // Second half of a 16-bit pair carries the upper 12 bits
  assign commit_word = cfg.half_width_bus_select ?
    {st_q.wr_data[11:0], st_q.wr_lo} : st_q.wr_data; // [RULE22]

  assign soft_full = commit && (wr_idx == `TDC_IDX_W4) &&
                     commit_word[`TDC_B_FULL_RST];
  assign soft_red = commit && (wr_idx == `TDC_IDX_W4) &&
                    commit_word[`TDC_B_RED_RST];
  assign soft_trig = commit && (wr_idx == `TDC_IDX_W4) &&
                     commit_word[`TDC_B_SOFT_TRIG];

  // Pin-driven resets repeat every cycle the level is held
  assign pin_full =
    (!cfg.quiet_mode && w5[`TDC_B_RST_TRIG_FULL] && st_q.s2.trig) ||
    (gate_pin_unused_in && w5[`TDC_B_RST_GATE_FULL] &&
     !st_q.s2.gate_n); // [RULE13] [RULE14]
  assign pin_red =
    (!cfg.quiet_mode && w5[`TDC_B_RST_TRIG_RED] && st_q.s2.trig) ||
    (gate_pin_unused_in && w5[`TDC_B_RST_GATE_RED] &&
     !st_q.s2.gate_n); // [RULE13] [RULE14]

  assign any_rst = st_q.full_rst || st_q.red_rst;
  assign trig_rise = st_q.s2.trig && !st_q.trig_prev;

  // ==========================================================
  // Read word
  // ==========================================================
  always_comb begin
    rd_word = `TDC_RESET_WORD;
    if (rd_idx != `TDC_IDX_NONE) begin
      rd_word = st_q.regs[rd_idx]; // [RULE23]
    end
    if (rd_idx == `TDC_IDX_W6) begin
      rd_word = rd_word ^ `TDC_FILL_INV; // [RULE16]
    end
  end

  // ==========================================================
  // Reference-period arithmetic
  // ==========================================================
  // One clock spans several reference periods, so launches and
  // expiry land on the first clock at or past the programmed count
  assign launch_span = {2'h0, cfg.internal_launch_period} + 10'h001;
  assign launch_next = st_q.launch_acc +
                       10'(`TDC_REF_PER_CLK); // [RULE24]
  assign timer_next = st_q.timer_acc + 14'(`TDC_REF_PER_CLK); // [RULE24]
  assign timer_go = !st_q.timer_run &&
    ((launch_in && cfg.window_timer_on_launch) ||
     (hit_in && cfg.window_timer_on_hit)); // [RULE10]

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.trig_prev = st_q.s2.trig;
    st_d.launch_pulse = 1'b0;
    st_d.timer_done = 1'b0;
    st_d.full_rst = soft_full || pin_full; // [RULE7] [RULE25]
    st_d.red_rst = soft_red || pin_red; // [RULE8] [RULE25]

    case (st_q.bus)
      tdc_pkg::BUS_IDLE: begin
        if (!st_q.s2.csn && !st_q.s2.wrn) begin
          st_d.bus = tdc_pkg::BUS_WRITE;
          st_d.wr_data = st_q.s2.data;
        end else if (!st_q.s2.csn && !st_q.s2.rdn) begin
          st_d.bus = tdc_pkg::BUS_READ;
          if (!cfg.half_width_bus_select) begin
            st_d.rd_data = rd_word;
          end else if (st_q.rd_half) begin
            st_d.rd_data = {16'h0000, 12'(rd_word[27:16])}; // [RULE22]
          end else begin
            st_d.rd_data = {12'h000, rd_word[15:0]}; // [RULE22]
          end
        end
      end
      tdc_pkg::BUS_WRITE: begin
        if (!st_q.s2.wrn) begin
          st_d.wr_data = st_q.s2.data;
        end else begin
          st_d.bus = tdc_pkg::BUS_IDLE;
          if (cfg.half_width_bus_select && !st_q.wr_half) begin
            st_d.wr_lo = st_q.wr_data[15:0]; // [RULE22]
            st_d.wr_half = 1'b1;
          end else begin
            st_d.wr_half = 1'b0;
            if (wr_idx == `TDC_IDX_W4) begin
              st_d.regs[wr_idx] =
                commit_word & ~`TDC_W4_PULSE_MASK; // [RULE25]
            end else if (wr_idx != `TDC_IDX_NONE) begin
              st_d.regs[wr_idx] = commit_word;
            end
          end
        end
      end
      tdc_pkg::BUS_READ: begin
        if (st_q.s2.rdn || st_q.s2.csn) begin
          st_d.bus = tdc_pkg::BUS_IDLE;
          st_d.rd_half = cfg.half_width_bus_select &&
                         !st_q.rd_half; // [RULE22]
        end
      end
      default: begin
        st_d.bus = tdc_pkg::BUS_IDLE;
      end
    endcase

    // Quiet mode waits for a trigger edge or the soft trigger
    if (trig_rise || soft_trig) begin
      st_d.armed = 1'b1; // [RULE4]
    end else if (any_rst) begin
      st_d.armed = 1'b0;
    end

    // Internal launch generator, I-mode only
    if (!i_mode_in || any_rst) begin
      st_d.launch_acc = 10'h000;
    end else if (launch_next >= launch_span) begin
      st_d.launch_acc = launch_next - launch_span; // [RULE3]
      st_d.launch_pulse = 1'b1; // [RULE3]
    end else begin
      st_d.launch_acc = launch_next;
    end

    // A launch seen in the reset cycle still counts
    if (launch_in) begin
      st_d.launched = 1'b1; // [RULE12]
    end else if (any_rst) begin
      st_d.launched = 1'b0;
    end

    // Window timer
    if (any_rst) begin
      st_d.timer_run = 1'b0;
      st_d.timer_acc = 14'h0000;
    end else if (timer_go) begin
      st_d.timer_run = 1'b1; // [RULE10]
      st_d.timer_acc = 14'h0000;
    end else if (st_q.timer_run) begin
      if (timer_next >= {1'b0, cfg.window_timer_count}) begin
        st_d.timer_run = 1'b0; // [RULE21]
        st_d.timer_done = 1'b1; // [RULE21]
      end else begin
        st_d.timer_acc = timer_next;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '{s1: '{csn: 1'b1, rdn: 1'b1, wrn: 1'b1,
                     adr: 4'h0, data: 28'h0000000,
                     trig: 1'b0, gate_n: 1'b1},
                s2: '{csn: 1'b1, rdn: 1'b1, wrn: 1'b1,
                     adr: 4'h0, data: 28'h0000000,
                     trig: 1'b0, gate_n: 1'b1},
                bus: tdc_pkg::BUS_IDLE,
                regs: '{default: `TDC_RESET_WORD},
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign bus_data_out = st_q.rd_data;
  assign bus_data_oe_n_out = (st_q.bus != tdc_pkg::BUS_READ);
  assign postproc_enable_out = !cfg.quiet_mode || st_q.armed; // [RULE4]
  assign internal_launch_out = st_q.launch_pulse;
  assign window_timer_end_out = st_q.timer_done;
  assign hit_enable_out = !(cfg.hit_block_until_launch &&
                            !st_q.launched); // [RULE12]
  assign launch_enable_out = !(cfg.launch_block_after_launch &&
                               st_q.launched); // [RULE12]
  assign full_reset_out = st_q.full_rst;
  assign reduced_reset_out = st_q.red_rst;
  assign load_level_flags[0] = fifo1_level_in >= cfg.fill_level; // [RULE15]
  assign load_level_flags[1] = fifo2_level_in >= cfg.fill_level; // [RULE15]
  assign empty_flag_pin = empty_in;
  // Without the option the pin is driven only while it shows empty
  assign empty_pin_oe_n_out =
    !(cfg.empty_pin_always_driven || empty_in); // [RULE9]

endmodule // tdc_cfg_bank

/* File: tb/tdc_cfg_bank_chk.sv */
// Port checks of the configuration bank
module tdc_cfg_bank_chk (
  input wire logic mclk_in, // Clock
  input wire logic reset_in, // Asynchronous reset, high
  input wire logic bus_cs_n_in, // Chip select
  input wire logic bus_rd_n_in, // Read strobe
  input wire logic bus_data_oe_n_out, // Data pin enable
  input wire logic g_mode_in, // G-mode
  input wire logic i_mode_in, // I-mode
  input wire logic [7:0] fifo1_level_in, // FIFO1 occupancy
  input wire logic [7:0] fifo2_level_in, // FIFO2 occupancy
  input wire logic empty_in, // FIFO empty state
  input wire logic single_ended_launch_input, // Single-ended launch
  input wire logic [7:0] se_stop_in, // Single-ended stops
  input wire logic diff_launch_input, // Differential launch
  input wire logic [1:0] diff_stop_in, // Differential stops
  input wire logic [2:0] diff_path_out, // Differential paths
  input wire logic [7:0] stop_ch_out, // Stop channel sources
  input tdc_pkg::tdc_cfg_s cfg_out, // Configuration
  input wire logic [17:0] launch_offset_out, // Applied offset
  input wire logic postproc_enable_out, // Postproc enable
  input wire logic hit_enable_out, // Hits accepted
  input wire logic launch_enable_out, // Launches accepted
  input wire logic full_reset_out, // Full reset pulse
  input wire logic reduced_reset_out, // Reduced reset pulse
  input wire logic [1:0] load_level_flags, // Fill-level flags
  input wire logic empty_flag_pin, // Empty pin level
  input wire logic empty_pin_oe_n_out // Empty pin enable
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // ==========================================================
  // Bus and register side
  chk_read_cause: assert property ($fell(bus_data_oe_n_out) |->
    $past(!bus_rd_n_in && !bus_cs_n_in)) else $error("drive without read");
  chk_read_release: assert property ($rose(bus_rd_n_in) |->
    ##[1:4] bus_data_oe_n_out) else $error("pins not released");
  chk_full_keeps: assert property (full_reset_out |=>
    $stable(cfg_out)) else $error("full reset changed cfg");
  chk_red_keeps: assert property (reduced_reset_out |=>
    $stable(cfg_out)) else $error("reduced reset changed cfg");

  // ==========================================================
  // Decoded outputs
  chk_fill_flags: assert property (load_level_flags ==
    {fifo2_level_in >= cfg_out.fill_level,
     fifo1_level_in >= cfg_out.fill_level}) else $error("fill flags wrong");
  chk_empty_drive: assert property (cfg_out.empty_pin_always_driven |->
    !empty_pin_oe_n_out && empty_flag_pin == empty_in)
    else $error("empty pin not driven");
  chk_hit_open: assert property (!cfg_out.hit_block_until_launch |->
    hit_enable_out && (cfg_out.launch_block_after_launch || launch_enable_out))
    else $error("inputs blocked");
  chk_offset_sum: assert property (launch_offset_out == (g_mode_in ?
    18'(cfg_out.launch_offset_a + cfg_out.launch_offset_b) :
    cfg_out.launch_offset_a)) else $error("launch offset wrong");
  chk_test_route: assert property (diff_path_out ==
    (cfg_out.single_ended_to_diff_test ?
     {se_stop_in[1], se_stop_in[0], single_ended_launch_input} :
     {diff_stop_in, diff_launch_input})) else $error("path routing wrong");
  chk_stop_fanout: assert property (i_mode_in &&
    cfg_out.diff_input_fanout_select |-> stop_ch_out == {4{diff_stop_in}})
    else $error("stop fanout wrong");
  chk_quiet_off: assert property (!cfg_out.quiet_mode |->
    postproc_enable_out) else $error("postproc held");
endmodule // tdc_cfg_bank_chk

bind tdc_cfg_bank tdc_cfg_bank_chk u_chk (.*);

/* File: tb/tdc_host_model.sv */
// Host processor on the asynchronous parallel bus
module tdc_host_model (
  input wire logic clk_in, // Bus timing reference
  output logic cs_n_out, // Chip select
  output logic rd_n_out, // Read strobe
  output logic wr_n_out, // Write strobe
  output logic [3:0] adr_out, // Word address
  output logic [27:0] data_out, // Host side of data pins
  input wire logic [27:0] data_in, // Resolved data pins
  input wire logic oe_n_in // Device drive enable
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    adr_out = 4'h0;
    data_out = 28'h0000000;
  end

  // Five-clock strobes outlast the pin sync
  task automatic write(input logic [3:0] a, input logic [27:0] d);
    @(negedge clk_in);
    adr_out = a;
    data_out = d;
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    repeat (5) @(negedge clk_in);
    wr_n_out = 1'b1;
    cs_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    // Released pins show the inverse of the data
    data_out = ~d;
  endtask

  task automatic read(input logic [3:0] a, output logic [27:0] d,
                      output logic ok);
    @(negedge clk_in);
    adr_out = a;
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    repeat (5) @(posedge clk_in);
    d = data_in;
    ok = !oe_n_in;
    @(negedge clk_in);
    rd_n_out = 1'b1;
    cs_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask
endmodule // tdc_host_model

/* File: tb/tdc_cfg_bank_tb.sv */
// Bench for the configuration bank
module tdc_cfg_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] adr; logic [27:0] wr; logic [27:0] rd;} tdc_row_s;
  logic mclk_in, reset_in, cs_n, rd_n, wr_n, oe_n, trig, gate, gate_unused;
  logic i_mode, launch, hit, empty_pin, empty_oe_n, postproc, ilaunch, tend;
  logic full_rst, red_rst, ok;
  logic [3:0] adr;
  logic [27:0] host_d, dev_d, wire_d, rd_v;
  logic [7:0] fifo1, fifo2, stim_q;
  logic [1:0] flags;
  int failures, checks, full_cnt, red_cnt, launch_cnt, n;
  tdc_row_s rows[7];
  tdc_row_s pins[4];

  // ==========================================================
  // Clock, stimulus, data pins
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial stim_q = 8'h00;
  always @(negedge mclk_in) stim_q <= stim_q + 8'h01;
  always @(posedge mclk_in) begin
    full_cnt += int'(full_rst === 1'b1);
    red_cnt += int'(red_rst === 1'b1);
    launch_cnt += int'(ilaunch === 1'b1);
  end
  assign wire_d = oe_n ? host_d : dev_d;

  tdc_host_model u_tdc_host_model (.clk_in(mclk_in), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .adr_out(adr), .data_out(host_d),
    .data_in(wire_d), .oe_n_in(oe_n));

  tdc_cfg_bank u_tdc_cfg_bank (.mclk_in(mclk_in), .reset_in(reset_in),
    .bus_cs_n_in(cs_n), .bus_rd_n_in(rd_n), .bus_wr_n_in(wr_n),
    .bus_adr_in(adr), .bus_data_in(wire_d), .bus_data_out(dev_d),
    .bus_data_oe_n_out(oe_n), .trigger_pin_in(trig),
    .output_gate_pin_in(gate), .gate_pin_unused_in(gate_unused),
    .i_mode_in(i_mode), .g_mode_in(stim_q[3]), .launch_in(launch),
    .hit_in(hit), .fifo1_level_in(fifo1), .fifo2_level_in(fifo2),
    .empty_in(stim_q[2]), .single_ended_launch_input(stim_q[0]),
    .se_stop_in(stim_q), .diff_launch_input(stim_q[5]),
    .diff_stop_in(stim_q[7:6]), .diff_path_out(), .stop_ch_out(),
    .cfg_out(), .launch_offset_out(), .postproc_enable_out(postproc),
    .internal_launch_out(ilaunch), .window_timer_end_out(tend),
    .hit_enable_out(), .launch_enable_out(), .full_reset_out(full_rst),
    .reduced_reset_out(red_rst), .load_level_flags(flags),
    .empty_flag_pin(empty_pin), .empty_pin_oe_n_out(empty_oe_n));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Pulse launch or hit, count clocks to expiry
  task automatic timer_run(input logic use_hit, input int exp);
    @(negedge mclk_in);
    {hit, launch} = {use_hit, !use_hit};
    @(posedge mclk_in);
    @(negedge mclk_in);
    {hit, launch} = 2'b00;
    for (n = 1; n < 40; n++) begin
      @(posedge mclk_in);
      #1;
      if (tend === 1'b1) break;
    end
    check(28'(n), 28'(exp));
  endtask

  initial begin
    #5_000_000;
    failures++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {trig, gate, gate_unused, i_mode, launch, hit} = 6'b010000;
    {fifo1, fifo2} = {8'h12, 8'h11};
    rows = '{'{4'h3, 28'h800001f, 28'h800001f}, '{4'h4, 28'h0000307,
      28'h0000307}, '{4'h5, 28'h0601234, 28'h0601234}, '{4'h6, 28'hc012312,
      28'hc0123ed}, '{4'h7, 28'h0143fb7, 28'h0143fb7}, '{4'he, 28'h0000000,
      28'h0000000}, '{4'h9, 28'h5a5a5a5, 28'h0000000}};
    pins = '{'{4'h0, 28'h0800000, 28'h1}, '{4'h1, 28'h1000000, 28'h2},
      '{4'h2, 28'h2000000, 28'h1}, '{4'h3, 28'h4000000, 28'h2}};
    reset_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    reset_in = 1'b0;
    check(28'(postproc), 28'h1);
    u_tdc_host_model.read(4'h3, rd_v, ok);
    check(rd_v, 28'h0000000);
    // Quiet, M-mode, zero pulse-pair
    foreach (rows[i]) u_tdc_host_model.write(rows[i].adr, rows[i].wr);
    foreach (rows[i]) begin
      u_tdc_host_model.read(rows[i].adr, rd_v, ok);
      check(rd_v, rows[i].rd);
    end
    check(28'(flags), 28'h1);
    // Commands self clear, fire once
    {full_cnt, red_cnt} = 0;
    u_tdc_host_model.write(4'h4, 28'h0400307);
    check(28'(full_cnt), 28'h1);
    check(28'(postproc), 28'h0);
    u_tdc_host_model.write(4'h4, 28'h1000307);
    check(28'(postproc), 28'h1);
    u_tdc_host_model.write(4'h4, 28'h0800307);
    check(28'(red_cnt), 28'h1);
    check(28'(postproc), 28'h0);
    trig = 1'b1;
    repeat (5) @(negedge mclk_in);
    trig = 1'b0;
    check(28'(postproc), 28'h1);
    u_tdc_host_model.read(4'h4, rd_v, ok);
    check(rd_v, 28'h0000307);
    // N = 7: launch every two clocks
    i_mode = 1'b1;
    @(negedge mclk_in);
    launch_cnt = 0;
    repeat (20) @(negedge mclk_in);
    check(28'(launch_cnt), 28'd10);
    u_tdc_host_model.write(4'h4, 28'h4000307);
    timer_run(1'b0, 10);
    u_tdc_host_model.write(4'h4, 28'h8000307);
    timer_run(1'b1, 10);
    u_tdc_host_model.write(4'h7, 28'h0003fb7);
    timer_run(1'b1, 1);
    // Pin resets: quiet off, gate pin free
    u_tdc_host_model.write(4'h4, 28'h0000007);
    gate_unused = 1'b1;
    foreach (pins[i]) begin
      u_tdc_host_model.write(4'h5, pins[i].wr);
      {full_cnt, red_cnt} = 0;
      {trig, gate} = {pins[i].adr < 4'h2, pins[i].adr > 4'h1 ? 1'b0 : 1'b1};
      repeat (4) @(negedge mclk_in);
      {trig, gate} = 2'b01;
      repeat (4) @(negedge mclk_in);
      check(28'({red_cnt > 0, full_cnt > 0}), pins[i].rd);
    end
    // Paired half-width transfers
    u_tdc_host_model.write(4'he, 28'h0000010);
    u_tdc_host_model.write(4'h3, 28'h0000015);
    u_tdc_host_model.write(4'h3, 28'h0000800);
    u_tdc_host_model.read(4'h3, rd_v, ok);
    check(rd_v & 28'h000ffff, 28'h0000015);
    u_tdc_host_model.read(4'h3, rd_v, ok);
    check(rd_v & 28'h0000fff, 28'h0000800);
    check(28'(ok), 28'h1);
    finish_test();
  end
endmodule // tdc_cfg_bank_tb
